// ### xfer_resume.sv
// Transfer output scaling and power-on resume logic with an AHB-Lite register slave.
`timescale 1ns/1ps
`default_nettype none
`include "xfer_defs.svh"
module xfer_resume #(
	parameter bit HAS_LINEAR = 1'b1
) (
	// Clock and reset
	input  wire logic                  clk_i,
	input  wire logic                  rst_b_i,
	// AHB-Lite slave
	input  wire logic                  hsel_i,
	input  wire logic [11:0]           haddr_i,
	input  wire logic [1:0]            htrans_i,
	input  wire logic                  hwrite_i,
	input  wire logic [2:0]            hsize_i,
	input  wire logic                  hready_i,
	input  wire logic [31:0]           hwdata_i,
	output var  logic [31:0]           hrdata_o,
	output var  logic                  hreadyout_o,
	output var  logic                  hresp_o,
	// Retained storage port
	input  wire xfer_pkg::saved_state_t nv_state_i,
	output var  xfer_pkg::saved_state_t nv_state_o,
	output var  logic                  nv_we_o,
	// Control state and transfer outputs
	output var  logic                  run_o,
	output var  logic                  manual_o,
	output var  logic [15:0]           mv_o,
	output var  xfer_pkg::xfer_out_t   xfer1_o,
	output var  xfer_pkg::xfer_out_t   xfer2_o
);
	import xfer_pkg::*;

	logic        rst_s1;
	logic        rst_s2;
	logic        ap_wr;
	logic [11:0] ap_addr;
	logic [1:0]  resume_pend;
	logic [1:0]  resume_act;
	logic [7:0]  assign1;
	logic [7:0]  assign2;
	logic [1:0]  lintype;
	logic [15:0] scale_hi [2];
	logic [15:0] scale_lo [2];
	logic [15:0] qty [6];
	logic [15:0] mv_init;
	logic [15:0] mv_stop;
	logic        onoff;
	logic        swrst;
	logic        run;
	logic        manual;
	logic [15:0] mv;
	logic [15:0] nv_run_mv;
	state_t      state;
	logic [4:0]  div_cnt;
	logic        div_ch;
	logic [31:0] num;
	logic [31:0] den;
	logic [31:0] quo;
	logic        neg;
	logic        bus_go;
	logic [31:0] next_rdata;

	// Reset is released through two flops; the rest of the design uses rst_s2.
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			rst_s1 <= 1'b0;
			rst_s2 <= 1'b0;
		end
		else
		begin
			rst_s1 <= 1'b1;
			rst_s2 <= rst_s1;
		end
	end

	function automatic logic [15:0] pick(input logic [7:0] code, input logic [15:0] q [6]);
		logic [15:0] r;
		r = 16'h0000;
		case (code)
			`ASG_PV:   r = q[0];
			`ASG_ISP:  r = q[1];
			`ASG_LSP:  r = q[2];
			`ASG_RSP:  r = q[3];
			`ASG_HEAT: r = q[4];
			`ASG_COOL: r = q[5];
			default:   r = 16'h0000;
		endcase
		return r;
	endfunction

	function automatic logic [15:0] clamp_pct(input logic [31:0] v);
		return (v > 32'(`PCT_FULL)) ? `PCT_FULL : v[15:0];
	endfunction

	assign bus_go = hsel_i && hready_i && htrans_i[1];

	// Address phase capture; every transfer is zero wait state with OKAY.
	always_ff @(posedge clk_i or negedge rst_s2)
	begin
		if (!rst_s2)
		begin
			ap_wr   <= 1'b0;
			ap_addr <= 12'h000;
		end
		else
		begin
			ap_wr   <= bus_go && hwrite_i;
			ap_addr <= haddr_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_s2)
	begin
		if (!rst_s2)
		begin
			hreadyout_o <= 1'b0;
			hresp_o     <= 1'b0;
		end
		else
		begin
			hreadyout_o <= 1'b1;
			hresp_o     <= 1'b0;
		end
	end

	// Configuration registers written by software.
	always_ff @(posedge clk_i or negedge rst_s2)
	begin
		if (!rst_s2)
		begin
			resume_pend <= `RESUME_CONTINUE;
			assign1     <= 8'h00;
			assign2     <= 8'h00;
			lintype     <= {2{`LINTYPE_4_20}};
			scale_hi    <= '{`SCALE_HI_RST, `SCALE_HI_RST};
			scale_lo    <= '{`SCALE_LO_RST, `SCALE_LO_RST};
			qty         <= '{default: 16'h0000};
			mv_init     <= `MV_ZERO;
			mv_stop     <= `MV_ZERO;
			onoff       <= 1'b0;
			swrst       <= 1'b0;
		end
		else
		begin
			swrst <= 1'b0;
			if (ap_wr)
			begin
				case (ap_addr)
					`OFS_CTRL:
					begin
						onoff <= hwdata_i[`CTRL_BIT_ONOFF];
						swrst <= hwdata_i[`CTRL_BIT_SWRST];
					end
					`OFS_RESUME:
						if (!run && hwdata_i[1:0] != 2'h3)
							resume_pend <= hwdata_i[1:0];
					`OFS_ASSIGN1:   assign1 <= hwdata_i[7:0];
					`OFS_ASSIGN2:   assign2 <= hwdata_i[7:0];
					`OFS_LINTYPE:
						if (HAS_LINEAR)
							lintype <= hwdata_i[1:0];
					`OFS_SCALE_HI1: scale_hi[0] <= hwdata_i[15:0];
					`OFS_SCALE_LO1: scale_lo[0] <= hwdata_i[15:0];
					`OFS_SCALE_HI2: scale_hi[1] <= hwdata_i[15:0];
					`OFS_SCALE_LO2: scale_lo[1] <= hwdata_i[15:0];
					`OFS_QTY_PV:    qty[0] <= hwdata_i[15:0];
					`OFS_QTY_ISP:   qty[1] <= hwdata_i[15:0];
					`OFS_QTY_LSP:   qty[2] <= hwdata_i[15:0];
					`OFS_QTY_RSP:   qty[3] <= hwdata_i[15:0];
					`OFS_QTY_HEAT:  qty[4] <= hwdata_i[15:0];
					`OFS_QTY_COOL:  qty[5] <= hwdata_i[15:0];
					`OFS_MV_INIT:   mv_init <= hwdata_i[15:0];
					`OFS_MV_STOP:   mv_stop <= hwdata_i[15:0];
					default:        ;
				endcase
			end
		end
	end

	// Resume sequencer and live control state. Reset restarts from ST_RESET; a
	// software reset re-enters the same path, but power-up runs it with resume_pend already back at continue.
	always_ff @(posedge clk_i or negedge rst_s2)
	begin
		if (!rst_s2)
		begin
			state      <= ST_RESET;
			resume_act <= `RESUME_CONTINUE;
			run        <= 1'b0;
			manual     <= 1'b0;
			mv         <= `MV_ZERO;
		end
		else
		begin
			case (state)
				ST_RESET:
				begin
					resume_act <= resume_pend;
					state      <= ST_RESUME;
				end
				ST_RESUME:
				begin
					state  <= ST_IDLE;
					run    <= (resume_act == `RESUME_STOP) ? 1'b0 : nv_state_i.run;
					if (onoff)
						manual <= 1'b0;
					else if (resume_act == `RESUME_MANUAL)
						manual <= 1'b1;
					else
						manual <= nv_state_i.manual;
					if (onoff)
						mv <= (resume_act == `RESUME_CONTINUE) ? nv_run_mv : `MV_ZERO;
					else if (nv_state_i.manual)
						mv <= nv_state_i.mv;
					else if (resume_act == `RESUME_CONTINUE && nv_state_i.run)
						mv <= mv_init;
					else
						mv <= mv_stop;
				end
				ST_IDLE, ST_DIV:
				begin
					if (swrst)
						state <= ST_RESET;
					if (ap_wr && ap_addr == `OFS_CTRL && !swrst)
					begin
						run    <= hwdata_i[`CTRL_BIT_RUN];
						manual <= onoff ? 1'b0 : hwdata_i[`CTRL_BIT_MAN];
					end
					if (ap_wr && ap_addr == `OFS_MV_LIVE)
						mv <= hwdata_i[15:0];
				end
				default: state <= ST_RESET;
			endcase
		end
	end

	// On/off continue resumes at either extreme; the saved value tells which one.
	assign nv_run_mv = (nv_state_i.mv != `MV_ZERO) ? `MV_FULL : `MV_ZERO;

	// Retained copy is refreshed whenever the live state differs from it while the sequencer is in ST_IDLE.
	always_ff @(posedge clk_i or negedge rst_s2)
	begin
		if (!rst_s2)
		begin
			nv_state_o <= '0;
			nv_we_o    <= 1'b0;
		end
		else
		begin
			nv_state_o <= '{run: run, manual: manual, mv: mv};
			nv_we_o    <= (state == ST_IDLE) &&
				(nv_state_i != saved_state_t'{run: run, manual: manual, mv: mv});
		end
	end

	// Serial restoring divider computes (q - lo) * 10000 / (hi - lo) for each channel.
	// A sign flag covers inverted scaling without a signed divider.
	always_ff @(posedge clk_i or negedge rst_s2)
	begin
		if (!rst_s2)
		begin
			div_cnt <= 5'h00;
			div_ch  <= 1'b0;
			num     <= 32'h00000000;
			den     <= 32'h00000000;
			quo     <= 32'h00000000;
			neg     <= 1'b0;
			xfer1_o <= '{linear: HAS_LINEAR, span_0_20: 1'b0, pct: 16'h0000};
			xfer2_o <= '{linear: HAS_LINEAR, span_0_20: 1'b0, pct: 16'h0000};
		end
		else if (div_cnt == 5'h00)
		begin : start
			logic signed [17:0] d;
			logic signed [17:0] n;
			logic [15:0]        q;
			q = pick(div_ch ? assign2 : assign1, qty);
			d = 18'(signed'(scale_hi[div_ch])) - 18'(signed'(scale_lo[div_ch]));
			n = 18'(signed'(q)) - 18'(signed'(scale_lo[div_ch]));
			neg     <= d[17] ^ n[17];
			num     <= 32'(n[17] ? -n : n) * 32'(`PCT_FULL);
			den     <= 32'(d[17] ? -d : d);
			quo     <= 32'h00000000;
			div_cnt <= 5'(`DIV_CYCLES);
		end
		else
		begin
			if (num >= (den << (div_cnt - 5'h1)) && den != 32'h0)
			begin
				num <= num - (den << (div_cnt - 5'h1));
				quo <= quo | (32'h1 << (div_cnt - 5'h1));
			end
			div_cnt <= div_cnt - 5'h1;
			if (div_cnt == 5'h01)
			begin
				div_ch <= !div_ch;
				xfer1_o.span_0_20 <= lintype[0];
				xfer2_o.span_0_20 <= lintype[1];
				if (!div_ch && HAS_LINEAR)
					xfer1_o.pct <= neg ? 16'h0000 : clamp_pct(quo | {31'h0, num >= den});
				if (div_ch && HAS_LINEAR)
					xfer2_o.pct <= neg ? 16'h0000 : clamp_pct(quo | {31'h0, num >= den});
			end
		end
	end

	always_comb
	begin
		next_rdata = 32'h00000000;
		case (haddr_i)
			`OFS_CTRL:    next_rdata = {28'h0, 1'b0, onoff, manual, run};
			`OFS_RESUME:  next_rdata = {28'h0, resume_act, resume_pend};
			`OFS_ASSIGN1: next_rdata = {24'h0, assign1};
			`OFS_ASSIGN2: next_rdata = {24'h0, assign2};
			`OFS_LINTYPE: next_rdata = {30'h0, lintype};
			`OFS_MV_LIVE: next_rdata = {16'h0, mv};
			`OFS_STATUS:  next_rdata = {27'h0, HAS_LINEAR, state};
			`OFS_XFER1:   next_rdata = {16'h0, xfer1_o.pct};
			`OFS_XFER2:   next_rdata = {16'h0, xfer2_o.pct};
			default:      next_rdata = 32'h00000000;
		endcase
	end

	// Read data is decoded during the address phase so it stands in the data phase
	// with no wait state. A read placed right behind a write sees the older value.
	always_ff @(posedge clk_i or negedge rst_s2)
	begin
		if (!rst_s2)
			hrdata_o <= 32'h00000000;
		else
			hrdata_o <= (bus_go && !hwrite_i) ? next_rdata : 32'h00000000;
	end

	always_ff @(posedge clk_i or negedge rst_s2)
	begin
		if (!rst_s2)
		begin
			run_o    <= 1'b0;
			manual_o <= 1'b0;
			mv_o     <= `MV_ZERO;
		end
		else
		begin
			run_o    <= run;
			manual_o <= manual;
			mv_o     <= mv;
		end
	end
endmodule
`default_nettype wire

// ### xfer_defs.svh
// Constants: register offsets, field codes, reset values and timing counts.
// Function
// - Only linear-output units may turn outputs 1 and 2 into transfer outputs.
// - Transfer source: process value, internal, local, remote set point, heat, cool.
// - Assignment code 43 selects channel 1 process value.
// - Linear type 0 is 4-20 mA (default), 1 is 0-20 mA.
// - Linear type setting is refused on units without linear outputs.
// - Transfer span comes from the output scaling upper and lower limits.
// - Upper limit below lower limit gives a falling, inverted output.
// - Resume mode 0 continue (default), 1 stop, 2 manual.
// - Resume behaviour applies after software reset and after power-up.
// - Resume mode write is refused while control is running.
// - A new resume mode takes effect only at the next reset or power-up; power-up resets resume_pend to continue, so only a software reset applies it.
// - Continue under PID restores saved run/stop and auto/manual states.
// - Continue, prior auto: running starts at initial value, stopped at stop value.
// - Prior manual in any mode restores the held manipulated value.
// - On/off control forces auto; continue resumes at 0.0% or 100.0%.
// - Stop mode forces stopped, keeps auto/manual; prior auto uses stop value.
// - Manual mode forces manual, keeps run/stop; prior auto uses stop value.
// - Output is 100% at upper limit, 0% at lower limit, linear between.
`ifndef XFER_DEFS_SVH
`define XFER_DEFS_SVH

`define OFS_CTRL        12'h000
`define OFS_RESUME      12'h004
`define OFS_ASSIGN1     12'h008
`define OFS_ASSIGN2     12'h00c
`define OFS_LINTYPE     12'h010
`define OFS_SCALE_HI1   12'h014
`define OFS_SCALE_LO1   12'h018
`define OFS_SCALE_HI2   12'h01c
`define OFS_SCALE_LO2   12'h020
`define OFS_QTY_PV      12'h024
`define OFS_QTY_ISP     12'h028
`define OFS_QTY_LSP     12'h02c
`define OFS_QTY_RSP     12'h030
`define OFS_QTY_HEAT    12'h034
`define OFS_QTY_COOL    12'h038
`define OFS_MV_INIT     12'h03c
`define OFS_MV_STOP     12'h040
`define OFS_MV_LIVE     12'h044
`define OFS_STATUS      12'h048
`define OFS_XFER1       12'h04c
`define OFS_XFER2       12'h050

`define CTRL_BIT_RUN    0
`define CTRL_BIT_MAN    1
`define CTRL_BIT_ONOFF  2
`define CTRL_BIT_SWRST  3

`define ASG_PV          8'h2b
`define ASG_ISP         8'h2c
`define ASG_LSP         8'h2d
`define ASG_RSP         8'h2e
`define ASG_HEAT        8'h2f
`define ASG_COOL        8'h30

`define RESUME_CONTINUE 2'h0
`define RESUME_STOP     2'h1
`define RESUME_MANUAL   2'h2

`define LINTYPE_4_20    1'h0
`define LINTYPE_0_20    1'h1

`define SCALE_HI_RST    16'h0064
`define SCALE_LO_RST    16'h0000
`define MV_FULL         16'h03e8
`define MV_ZERO         16'h0000
`define PCT_FULL        16'h2710

`define DIV_CYCLES      18
`endif

// ### xfer_pkg.sv
// Types shared by the transfer output and resume logic.
package xfer_pkg;
	typedef struct packed {
		logic        run;
		logic        manual;
		logic [15:0] mv;
	} saved_state_t;

	typedef struct packed {
		logic        linear;
		logic        span_0_20;
		logic [15:0] pct;
	} xfer_out_t;

	typedef enum logic [3:0] {
		ST_RESET  = 4'h1,
		ST_RESUME = 4'h2,
		ST_IDLE   = 4'h4,
		ST_DIV    = 4'h8
	} state_t;
endpackage

// ### nv_store.sv
// Retained storage model that keeps the saved control state through any reset.
`timescale 1ns/1ps
`default_nettype none
module nv_store
	import xfer_pkg::*;
(
	// Clock and write port
	input  wire logic   clk_i,
	input  wire logic   we_i,
	input  wire saved_state_t d_i,
	// Stored state
	output var  saved_state_t q_o
);
	// No reset input on purpose: a power loss must not clear the store.
	initial q_o = '0;
	always @(posedge clk_i)
		if (we_i === 1'b1)
			q_o <= d_i;
endmodule
`default_nettype wire

// ### xfer_resume_asserts.sv
// Port checker for the transfer output and resume block.
`timescale 1ns/1ps
`default_nettype none
`include "xfer_defs.svh"
module xfer_resume_chk
	import xfer_pkg::*;
#(
	parameter bit HAS_LINEAR = 1'b1
) (
	input wire logic         clk_i,
	input wire logic         rst_b_i,
	input wire logic         hsel_i,
	input wire logic [11:0]  haddr_i,
	input wire logic [1:0]   htrans_i,
	input wire logic         hwrite_i,
	input wire logic         hready_i,
	input wire logic [31:0]  hwdata_i,
	input wire logic         hreadyout_o,
	input wire logic         hresp_o,
	input wire saved_state_t nv_state_o,
	input wire logic         nv_we_o,
	input wire logic         run_o,
	input wire xfer_out_t    xfer1_o,
	input wire xfer_out_t    xfer2_o
);
	logic ctl_q;
	logic hit_q;
	logic run_q;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	// A control write that also asks for a software reset is left out: resume overrides it.
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			ctl_q <= 1'b0;
			hit_q <= 1'b0;
			run_q <= 1'b0;
		end
		else
		begin
			ctl_q <= hsel_i && hready_i && htrans_i[1] && hwrite_i && haddr_i == `OFS_CTRL;
			hit_q <= ctl_q && !hwdata_i[`CTRL_BIT_SWRST];
			if (ctl_q)
				run_q <= hwdata_i[`CTRL_BIT_RUN];
		end
	end
	hresp_okay_a: assert property (hresp_o == 1'b0)
		else $error("bus response not OKAY");
	ready_held_a: assert property ($past(hreadyout_o) |-> hreadyout_o)
		else $error("slave inserted a wait state");
	lin_flag_a: assert property (xfer1_o.linear == HAS_LINEAR && xfer2_o.linear == HAS_LINEAR)
		else $error("transfer linear flag wrong");
	pct1_range_a: assert property (xfer1_o.pct <= `PCT_FULL)
		else $error("transfer 1 above full scale");
	pct2_range_a: assert property (xfer2_o.pct <= `PCT_FULL)
		else $error("transfer 2 above full scale");
	nv_clear_a: assert property (nv_we_o |-> ##[1:20] !nv_we_o)
		else $error("retained store write never completes");
	ctl_run_a: assert property (hit_q |-> ##[0:2] run_o == run_q)
		else $error("run state not taken from control write");
	ctl_nv_a: assert property (hit_q |-> ##[0:3] nv_state_o.run == run_q)
		else $error("saved run state not updated");
	cover property (hit_q && run_q);
	cover property (nv_we_o);
	cover property (xfer2_o.pct != 16'h0000);
endmodule
bind xfer_resume xfer_resume_chk #(.HAS_LINEAR(HAS_LINEAR)) chk_i (.clk_i(clk_i),
	.rst_b_i(rst_b_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
	.hwrite_i(hwrite_i), .hready_i(hready_i), .hwdata_i(hwdata_i), .hreadyout_o(hreadyout_o),
	.hresp_o(hresp_o), .nv_state_o(nv_state_o), .nv_we_o(nv_we_o), .run_o(run_o),
	.xfer1_o(xfer1_o), .xfer2_o(xfer2_o));
`default_nettype wire

// ### transfer_output_power_on_resume_tb_top.sv
// Self-checking bench for the transfer output and resume block.
`timescale 1ns/1ps
`default_nettype none
`include "xfer_defs.svh"
module transfer_output_power_on_resume_tb_top;
	import xfer_pkg::*;
	logic         clk = 1'b0;
	logic         rst_b = 1'b0;
	logic         hsel = 1'b0;
	logic         hwrite = 1'b0;
	logic [11:0]  haddr = 12'h000;
	logic [1:0]   htrans = 2'h0;
	logic [31:0]  hwdata = 32'h0;
	logic [31:0]  hrdata;
	logic [31:0]  rd;
	logic         hrdy;
	logic         run;
	logic         man;
	logic         nvwe;
	logic [15:0]  mv;
	saved_state_t nvq;
	saved_state_t nvd;
	xfer_out_t    x1;
	xfer_out_t    x2;
	logic [7:0]   rs = 8'h58;
	int           n_mismatch = 0;
	int           n_checks = 0;
	always #2 clk = ~clk;
	xfer_resume uut (.clk_i(clk), .rst_b_i(rst_b), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hready_i(hrdy), .hwdata_i(hwdata),
		.hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(), .nv_state_i(nvq), .nv_state_o(nvd),
		.nv_we_o(nvwe), .run_o(run), .manual_o(man), .mv_o(mv), .xfer1_o(x1), .xfer2_o(x2));
	nv_store nv (.clk_i(clk), .we_i(nvwe), .d_i(nvd), .q_o(nvq));
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask
	// Ready is sampled at the rising edge, the same value the slave acts on.
	task automatic wt;
		int n = 0;
		@(posedge clk);
		while (hrdy !== 1'b1)
		begin
			n++;
			n_mismatch += (n > 99);
			if (n > 99)
				report_and_stop();
			@(posedge clk);
		end
	endtask
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		wt();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wt();
		rd = hrdata;
	endtask
	function automatic logic [7:0] nx(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	function automatic logic [17:0] ex_st(input int m, input logic r, o, a, input logic [15:0] v);
		logic [15:0] ev;
		if (o)
			ev = (m == 0 && v != 0) ? `MV_FULL : `MV_ZERO;
		else if (a)
			ev = v;
		else
			ev = (m == 0 && r) ? 16'h0064 : 16'h00c8;
		return {m != 1 && r, !o && (m == 2 || a), ev};
	endfunction
	function automatic logic [31:0] ex_x(input int q, input int hi, input int lo);
		int r;
		r = (q - lo) * 10000 / (hi - lo);
		return 32'((r < 0) ? 0 : (r > 10000) ? 10000 : r);
	endfunction
	initial
	begin
		int m;
		int act;
		int q;
		int hi;
		int lo;
		logic r;
		logic o;
		logic a;
		logic [15:0] v;
		act = 0;
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		wt();
		bus(1'b0, `OFS_LINTYPE, 32'h0);
		chk(rd, 32'h0);
		bus(1'b0, `OFS_RESUME, 32'h0);
		chk(rd, 32'h0);
		bus(1'b1, `OFS_MV_INIT, 32'h64);
		bus(1'b1, `OFS_MV_STOP, 32'hc8);
		for (int i = 0; i < 12; i++)
		begin
			rs = nx(rs);
			m = rs % 3;
			r = rs[3];
			a = rs[4] || i == 11;
			o = m != 2 && rs[5] && i < 11;
			v = rs[6] ? 16'h0 : 16'(rs) * 16'h3;
			bus(1'b1, `OFS_CTRL, 32'h0);
			bus(1'b1, `OFS_RESUME, 32'(m));
			bus(1'b1, `OFS_CTRL, {29'h0, o, a, r});
			bus(1'b1, `OFS_MV_LIVE, {16'h0, v});
			if (r)
				bus(1'b1, `OFS_RESUME, 32'((m + 1) % 3));
			bus(1'b0, `OFS_RESUME, 32'h0);
			chk(rd, 32'(act * 4 + m));
			repeat (30) @(posedge clk);
			if (i == 11)
			begin
				rst_b <= 1'b0;
				repeat (6) @(posedge clk);
				rst_b <= 1'b1;
				wt();
				m = 0;
			end
			else
				bus(1'b1, `OFS_CTRL, {28'h0, 1'b1, o, a, r});
			repeat (12) @(negedge clk);
			chk({14'h0, run, man, mv}, {14'h0, ex_st(m, r, o, a, v)});
			act = m;
		end
		bus(1'b1, `OFS_CTRL, 32'h0);
		bus(1'b1, `OFS_LINTYPE, 32'h3);
		bus(1'b0, `OFS_LINTYPE, 32'h0);
		chk(rd, 32'h3);
		for (int k = 0; k < 8; k++)
		begin
			rs = nx(rs);
			q = (k < 6) ? int'(rs) * 4 - 200 : 0;
			lo = int'(rs[3:0]) * 10;
			hi = (k % 4 > 1) ? lo - 300 : lo + 300;
			bus(1'b1, 12'(`OFS_QTY_PV + 4 * (k % 6)), 32'(q));
			bus(1'b1, 12'(`OFS_ASSIGN1 + 4 * (k % 2)), 32'(43 + k));
			bus(1'b1, 12'(`OFS_SCALE_HI1 + 8 * (k % 2)), 32'(hi));
			bus(1'b1, 12'(`OFS_SCALE_LO1 + 8 * (k % 2)), 32'(lo));
			repeat (60) @(posedge clk);
			bus(1'b0, 12'(`OFS_XFER1 + 4 * (k % 2)), 32'h0);
			chk(rd, ex_x(q, hi, lo));
			chk(32'(k % 2 ? x2 : x1), 32'h30000 | ex_x(q, hi, lo));
		end
		report_and_stop();
	end
endmodule
`default_nettype wire
